// ===== logic/rcs_pkg.sv
// Package: register map, flag layout and timing for the reset controller
package rcs_pkg;
  // Register addresses on the plain port
  localparam logic [3:0] ADDR_BOR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PWR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CORE = 4'h3;
  // Brown-out control fields
  localparam int BC_SW_EN = 7;
  localparam int BC_FAST = 6;
  localparam int BC_READY = 0;
  localparam logic BC_SW_EN_RST = 1'b1;
  localparam logic BC_FAST_RST = 1'b0;
  // Power control fields
  localparam int PC_OVF = 7;
  localparam int PC_UNF = 6;
  localparam int PC_PIN = 3;
  localparam int PC_SOFT = 2;
  localparam int PC_POR = 1;
  localparam int PC_BOR = 0;
  localparam logic [7:0] PC_RESET_IMG = 8'h0C;
  localparam logic [7:0] PC_WR_MASK = 8'hCF;
  // Status fields
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  // Brown-out mode codes
  localparam logic [1:0] BOR_OFF = 2'h0;
  localparam logic [1:0] BOR_SW = 2'h1;
  localparam logic [1:0] BOR_NOSLEEP = 2'h2;
  localparam logic [1:0] BOR_ON = 2'h3;
  // Vectors
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int PWRT_MS = 64;
  localparam int PWRT_CYC = PWRT_MS * 1000 * CLK_MHZ;
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ST_RUN, ST_HOLD, ST_WAKE_STEP, ST_WAKE_IRQ
  } rcs_state_t;
endpackage

// ===== logic/rcs_filt_if.sv
// Interface: reset pin filter request and result
`timescale 1ns/100ps
interface rcs_filt_if;
  logic pin_low;
  logic enabled;
  logic hold;
  modport ctrl (output pin_low, output enabled, input hold);
  modport filt (input pin_low, input enabled, output hold);
endinterface

// ===== logic/rcs_pin_filter.sv
// Noise filter for the external reset pin path
`timescale 1ns/100ps
module rcs_pin_filter #(
  parameter int CYC = rcs_pkg::FILT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  rcs_filt_if.filt f
);
  logic [15:0] cnt_q, cnt_d;
  logic hold_q, hold_d;

  always_comb
  begin
    cnt_d = 16'h0000;
    hold_d = 1'b0;
    // Short low pulses never reach the count, so they are dropped
    if (f.enabled && f.pin_low)
    begin
      cnt_d = (cnt_q == 16'(CYC)) ? cnt_q : cnt_q + 16'h0001;
      hold_d = (cnt_q == 16'(CYC)) || hold_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt_q <= 16'h0000;
      hold_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end
  assign f.hold = hold_q;

  property p_short_ignored;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(f.pin_low) |-> !hold_q [*2];
  endproperty
  a_short_ignored: assert property (p_short_ignored)
    else $error("Reset pin hold rose too soon");
endmodule

// ===== logic/rcs_reset_ctrl.sv
// Reset cause recording and start-up sequencing controller
`timescale 1ns/100ps
module rcs_reset_ctrl #(
  parameter int PWRT_CYCLES = rcs_pkg::PWRT_CYC,
  parameter int FILT_CYCLES = rcs_pkg::FILT_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Configuration settings
  input wire logic [1:0] i_brownout_mode_cfg,
  input wire logic i_ext_reset_pin_enable,
  input wire logic i_low_voltage_prog,
  input wire logic i_stack_reset_enable,
  input wire logic i_powerup_timer_disable_n,
  // Reset and wake events
  input wire logic i_power_on,
  input wire logic i_brownout,
  input wire logic i_prog_exit,
  input wire logic i_osc_ready,
  input wire logic i_ext_reset_pin,
  input wire logic i_watchdog_timeout,
  input wire logic i_soft_reset,
  input wire logic i_stack_over,
  input wire logic i_stack_under,
  input wire logic i_irq_wake,
  input wire logic i_global_irq_enable,
  input wire logic i_sleeping,
  input wire logic [14:0] i_pc,
  // Analog brown-out detector
  input wire logic i_detector_active,
  // Outputs
  output logic o_core_reset,
  output logic o_pc_load,
  output logic [14:0] o_pc_value,
  output logic o_push_return,
  output logic o_detector_enable,
  output logic o_bandgap_force,
  output logic o_pin_is_gpio,
  output logic o_pullup_sw_ctrl
);
  // ----------------------------------------------------------------
  // Registers and local signals
  // ----------------------------------------------------------------
  logic sw_brownout_enable_q, sw_brownout_enable_d;
  logic brownout_fast_start_q, brownout_fast_start_d;
  logic [7:0] power_control_q, power_control_d;
  logic timeout_flag_n_q, timeout_flag_n_d;
  logic powerdown_flag_n_q, powerdown_flag_n_d;
  logic [7:0] rdata_q, rdata_d;
  logic [31:0] pwrt_q, pwrt_d;
  logic run_q, run_d;
  logic core_rst_q, core_rst_d;
  rcs_pkg::rcs_state_t state_q, state_d;
  logic pc_load_q, pc_load_d;
  logic [14:0] pc_value_q, pc_value_d;
  logic push_q, push_d;
  logic det_en_q, det_en_d;
  logic bg_q, bg_d;
  logic gpio_q, gpio_d;
  logic pin_en;
  logic cold;
  logic stack_ev;
  logic pin_rst;
  logic wdt_rst;
  logic any_rst;

  rcs_filt_if fif();

  // ----------------------------------------------------------------
  // Reset pin path
  // ----------------------------------------------------------------
  assign pin_en = i_ext_reset_pin_enable | i_low_voltage_prog;
  assign fif.pin_low = ~i_ext_reset_pin;
  assign fif.enabled = pin_en;

  rcs_pin_filter #(.CYC(FILT_CYCLES)) u_filt (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .f(fif.filt)
  );

  // Pulse at the start of a held pin reset only
  assign pin_rst = fif.hold & run_q;
  // Programming exit is folded into the cold path
  assign cold = i_power_on | i_prog_exit;
  assign stack_ev = i_stack_reset_enable & (i_stack_over | i_stack_under);
  assign wdt_rst = i_watchdog_timeout & ~i_sleeping;
  assign any_rst = cold | i_brownout | pin_rst | wdt_rst | i_soft_reset |
    stack_ev;

  // ----------------------------------------------------------------
  // Cause flags and control bits
  // ----------------------------------------------------------------
  always_comb
  begin
    sw_brownout_enable_d = sw_brownout_enable_q;
    brownout_fast_start_d = brownout_fast_start_q;
    power_control_d = power_control_q;
    timeout_flag_n_d = timeout_flag_n_q;
    powerdown_flag_n_d = powerdown_flag_n_q;
    // Software writes first, hardware events override
    if (i_wr && i_addr == rcs_pkg::ADDR_BOR_CTRL)
    begin
      sw_brownout_enable_d = i_wdata[rcs_pkg::BC_SW_EN];
      brownout_fast_start_d = i_wdata[rcs_pkg::BC_FAST];
    end
    if (i_wr && i_addr == rcs_pkg::ADDR_PWR_CTRL)
    begin
      power_control_d = i_wdata & rcs_pkg::PC_WR_MASK;
    end
    if (cold)
    begin
      power_control_d = rcs_pkg::PC_RESET_IMG;
      power_control_d[rcs_pkg::PC_BOR] = power_control_q[rcs_pkg::PC_BOR];
      timeout_flag_n_d = 1'b1;
      powerdown_flag_n_d = 1'b1;
      sw_brownout_enable_d = rcs_pkg::BC_SW_EN_RST;
      brownout_fast_start_d = rcs_pkg::BC_FAST_RST;
    end
    else if (i_brownout)
    begin
      // Power-on flag kept, everything else forced
      power_control_d = rcs_pkg::PC_RESET_IMG;
      power_control_d[rcs_pkg::PC_POR] = power_control_q[rcs_pkg::PC_POR];
      timeout_flag_n_d = 1'b1;
      powerdown_flag_n_d = 1'b1;
      sw_brownout_enable_d = rcs_pkg::BC_SW_EN_RST;
      brownout_fast_start_d = rcs_pkg::BC_FAST_RST;
    end
    else
    begin
      // Each event touches only its own flags; the rest hold
      if (pin_rst)
      begin
        power_control_d[rcs_pkg::PC_PIN] = 1'b0;
        if (i_sleeping)
        begin
          timeout_flag_n_d = 1'b1;
          powerdown_flag_n_d = 1'b0;
        end
      end
      if (i_soft_reset)
        power_control_d[rcs_pkg::PC_SOFT] = 1'b0;
      if (stack_ev && i_stack_over)
        power_control_d[rcs_pkg::PC_OVF] = 1'b1;
      if (stack_ev && i_stack_under)
        power_control_d[rcs_pkg::PC_UNF] = 1'b1;
      if (i_watchdog_timeout)
      begin
        timeout_flag_n_d = 1'b0;
        if (i_sleeping)
          powerdown_flag_n_d = 1'b0;
      end
      if (i_irq_wake && i_sleeping && !i_watchdog_timeout)
      begin
        timeout_flag_n_d = 1'b1;
        powerdown_flag_n_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sw_brownout_enable_q <= rcs_pkg::BC_SW_EN_RST;
      brownout_fast_start_q <= rcs_pkg::BC_FAST_RST;
      power_control_q <= rcs_pkg::PC_RESET_IMG;
      timeout_flag_n_q <= 1'b1;
      powerdown_flag_n_q <= 1'b1;
    end
    else
    begin
      sw_brownout_enable_q <= sw_brownout_enable_d;
      brownout_fast_start_q <= brownout_fast_start_d;
      power_control_q <= power_control_d;
      timeout_flag_n_q <= timeout_flag_n_d;
      powerdown_flag_n_q <= powerdown_flag_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencing and core control
  // ----------------------------------------------------------------
  always_comb
  begin
    pwrt_d = pwrt_q;
    run_d = run_q;
    state_d = state_q;
    pc_load_d = 1'b0;
    pc_value_d = pc_value_q;
    push_d = 1'b0;
    if (cold || i_brownout)
    begin
      // Timer restarts at the release of the supply event
      pwrt_d = i_powerup_timer_disable_n ? 32'h0 : 32'(PWRT_CYCLES);
      run_d = 1'b0;
      state_d = rcs_pkg::ST_HOLD;
    end
    else if (any_rst)
    begin
      run_d = 1'b0;
      state_d = rcs_pkg::ST_HOLD;
    end
    else
    begin
      // Timer counts even while the pin holds reset
      if (pwrt_q != 32'h0)
        pwrt_d = pwrt_q - 32'h1;
      unique case (state_q)
        rcs_pkg::ST_HOLD:
          // Detector readiness is not waited on in any brown-out mode
          if (pwrt_q == 32'h0 && i_osc_ready && !fif.hold)
          begin
            run_d = 1'b1;
            pc_load_d = 1'b1;
            pc_value_d = rcs_pkg::RESET_VECTOR;
            state_d = rcs_pkg::ST_RUN;
          end
        rcs_pkg::ST_RUN:
          if (i_sleeping && (i_watchdog_timeout || i_irq_wake))
          begin
            pc_load_d = 1'b1;
            pc_value_d = i_pc + 15'h0001;
            state_d = (i_irq_wake && !i_watchdog_timeout &&
              i_global_irq_enable) ? rcs_pkg::ST_WAKE_STEP :
              rcs_pkg::ST_RUN;
          end
        rcs_pkg::ST_WAKE_STEP:
          state_d = rcs_pkg::ST_WAKE_IRQ;
        rcs_pkg::ST_WAKE_IRQ:
        begin
          pc_load_d = 1'b1;
          push_d = 1'b1;
          pc_value_d = rcs_pkg::IRQ_VECTOR;
          state_d = rcs_pkg::ST_RUN;
        end
        default:
          state_d = rcs_pkg::ST_HOLD;
      endcase
    end
    core_rst_d = !run_d;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pwrt_q <= 32'h0;
      run_q <= 1'b0;
      core_rst_q <= 1'b1;
      state_q <= rcs_pkg::ST_HOLD;
      pc_load_q <= 1'b0;
      pc_value_q <= rcs_pkg::RESET_VECTOR;
      push_q <= 1'b0;
    end
    else
    begin
      pwrt_q <= pwrt_d;
      run_q <= run_d;
      core_rst_q <= core_rst_d;
      state_q <= state_d;
      pc_load_q <= pc_load_d;
      pc_value_q <= pc_value_d;
      push_q <= push_d;
    end
  end

  // ----------------------------------------------------------------
  // Detector and pin controls, register read
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (i_brownout_mode_cfg)
      rcs_pkg::BOR_ON: det_en_d = 1'b1;
      rcs_pkg::BOR_NOSLEEP: det_en_d = ~i_sleeping;
      rcs_pkg::BOR_SW: det_en_d = sw_brownout_enable_q;
      rcs_pkg::BOR_OFF: det_en_d = 1'b0;
    endcase
    bg_d = brownout_fast_start_q &&
      (i_brownout_mode_cfg == rcs_pkg::BOR_NOSLEEP ||
      i_brownout_mode_cfg == rcs_pkg::BOR_SW);
    gpio_d = ~pin_en;
    rdata_d = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        rcs_pkg::ADDR_BOR_CTRL:
        begin
          rdata_d[rcs_pkg::BC_SW_EN] = sw_brownout_enable_q;
          rdata_d[rcs_pkg::BC_FAST] = brownout_fast_start_q;
          rdata_d[rcs_pkg::BC_READY] = i_detector_active;
        end
        rcs_pkg::ADDR_PWR_CTRL: rdata_d = power_control_q;
        rcs_pkg::ADDR_STATUS:
        begin
          rdata_d[rcs_pkg::ST_TO] = timeout_flag_n_q;
          rdata_d[rcs_pkg::ST_PD] = powerdown_flag_n_q;
        end
        rcs_pkg::ADDR_CORE: rdata_d = {7'h00, run_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      det_en_q <= 1'b0;
      bg_q <= 1'b0;
      gpio_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      det_en_q <= det_en_d;
      bg_q <= bg_d;
      gpio_q <= gpio_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_core_reset = core_rst_q;
  assign o_pc_load = pc_load_q;
  assign o_pc_value = pc_value_q;
  assign o_push_return = push_q;
  assign o_detector_enable = det_en_q;
  assign o_bandgap_force = bg_q;
  assign o_pin_is_gpio = gpio_q;
  assign o_pullup_sw_ctrl = gpio_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_soft;
    i_soft_reset && !cold && !i_brownout;
  endsequence
  property p_soft_flag;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    s_soft |=> !power_control_q[rcs_pkg::PC_SOFT] && o_core_reset;
  endproperty
  a_soft_flag: assert property (p_soft_flag)
    else $error("Soft reset flag not cleared");
  property p_por_image;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    cold |=> power_control_q[7:1] == rcs_pkg::PC_RESET_IMG[7:1] &&
      timeout_flag_n_q;
  endproperty
  a_por_image: assert property (p_por_image)
    else $error("Power-on image wrong");
  property p_bor_image;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_brownout && !cold) |=> power_control_q[rcs_pkg::PC_BOR] == 1'b0
      && power_control_q[rcs_pkg::PC_PIN];
  endproperty
  a_bor_image: assert property (p_bor_image)
    else $error("Brown-out image wrong");
  property p_pin_sel;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    1 |=> o_pin_is_gpio == !$past(pin_en);
  endproperty
  a_pin_sel: assert property (p_pin_sel)
    else $error("Pin function select wrong");
  property p_wdt;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_watchdog_timeout && !cold && !i_brownout) |=> !timeout_flag_n_q;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("Time-out flag not cleared");
  property p_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    fif.hold |=> o_core_reset;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Core ran with pin reset held");
  property p_pwrt;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (cold && !i_powerup_timer_disable_n) |=> o_core_reset [*8];
  endproperty
  a_pwrt: assert property (p_pwrt)
    else $error("Power-up delay skipped");
  property p_irq;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    state_q == rcs_pkg::ST_WAKE_STEP |=> ##1 o_pc_load && o_push_return
      && o_pc_value == rcs_pkg::IRQ_VECTOR;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt vector not taken");
endmodule

// ===== testbench/rcs_pin_model.sv
// Partner model: driver of the external reset pin
`timescale 1ns/100ps
module rcs_pin_model (
  // Clock
  input wire logic i_clk,
  // Request
  input wire logic i_go,
  input wire logic [7:0] i_len,
  // Pin
  output logic o_pin,
  output logic o_busy
);
  logic [7:0] cnt_q = 8'h00;
  // Pin is driven high whenever no low pulse is counting
  always @(posedge i_clk)
  begin
    if (i_go)
      cnt_q <= i_len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign o_busy = cnt_q != 8'h00;
  assign o_pin = !o_busy;
endmodule

// ===== testbench/rcs_reset_ctrl_tb.sv
// Self-checking bench for the reset controller
`timescale 1ns/100ps
module rcs_reset_ctrl_tb;
  // ----
  // Stimulus and observation
  // ----
  localparam int PW = 20;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [1:0] mode = 2'h3;
  logic pin_en = 1'b1;
  logic low_voltage_prog = 1'b0;
  logic stk_en = 1'b1;
  logic pwrt_n = 1'b1;
  logic [7:0] evt = 8'h00;
  logic osc_ok = 1'b1;
  logic global_irq_enable = 1'b1;
  logic sleep = 1'b0;
  logic [14:0] pc = 15'h0000;
  logic det = 1'b0;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic pin, pin_busy, core_rst, pc_ld, push, det_en, bg, gpio, pull;
  logic [14:0] pc_val;
  logic [14:0] v;
  logic [7:0] r;
  logic [7:0] ini;
  int mismatches = 0;
  int n_tests = 0;
  int n;

  always #5 i_sys_clk = ~i_sys_clk;

  rcs_pin_model pm (.i_clk(i_sys_clk), .i_go(go), .i_len(len),
    .o_pin(pin), .o_busy(pin_busy));

  rcs_reset_ctrl #(.PWRT_CYCLES(PW), .FILT_CYCLES(3)) dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_brownout_mode_cfg(mode),
    .i_ext_reset_pin_enable(pin_en), .i_low_voltage_prog(low_voltage_prog),
    .i_stack_reset_enable(stk_en), .i_powerup_timer_disable_n(pwrt_n),
    .i_power_on(evt[0]), .i_brownout(evt[1]), .i_prog_exit(evt[2]),
    .i_osc_ready(osc_ok), .i_ext_reset_pin(pin),
    .i_watchdog_timeout(evt[3]), .i_soft_reset(evt[4]),
    .i_stack_over(evt[5]), .i_stack_under(evt[6]), .i_irq_wake(evt[7]),
    .i_global_irq_enable(global_irq_enable), .i_sleeping(sleep), .i_pc(pc),
    .i_detector_active(det), .o_core_reset(core_rst), .o_pc_load(pc_ld),
    .o_pc_value(pc_val), .o_push_return(push), .o_detector_enable(det_en),
    .o_bandgap_force(bg), .o_pin_is_gpio(gpio), .o_pullup_sw_ctrl(pull));

  function automatic logic f_det(input logic [1:0] m, input logic s,
    input logic sl);
    return m == rcs_pkg::BOR_ON || (m == rcs_pkg::BOR_NOSLEEP && !sl) ||
      (m == rcs_pkg::BOR_SW && s);
  endfunction
  function automatic logic f_bg(input logic [1:0] m, input logic f);
    return f && (m == rcs_pkg::BOR_NOSLEEP || m == rcs_pkg::BOR_SW);
  endfunction
  function automatic logic [7:0] f_flags(input int k, input logic [7:0] p);
    case (k)
      1: return {6'h03, p[1], 1'b0};
      2: return {6'h03, 1'b0, p[0]};
      4: return p & 8'hFB;
      5: return p | 8'h80;
      default: return p | 8'h40;
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 r = o_rdata;
  endtask
  task automatic ev(input int k);
    @(posedge i_sys_clk);
    evt <= 8'h01 << k;
    @(posedge i_sys_clk);
    evt <= 8'h00;
  endtask
  task automatic pin_low(input logic [7:0] l);
    @(posedge i_sys_clk);
    go <= 1'b1;
    len <= l;
    @(posedge i_sys_clk);
    go <= 1'b0;
  endtask
  // Bounded so a missing vector load cannot hang the run
  task automatic wait_load();
    n = 0;
    #1;
    while (pc_ld !== 1'b1 && n < 400)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    v = pc_val;
    if (n >= 400)
      chk(16'h0, 16'h1);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    give_verdict();
  end

  // ----
  // Test sequence
  // ----
  initial
  begin
    void'($urandom(5672));
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    rd(rcs_pkg::ADDR_PWR_CTRL);
    chk(r, 8'h0C);
    rd(rcs_pkg::ADDR_STATUS);
    chk(r, 8'h18);
    rd(rcs_pkg::ADDR_BOR_CTRL);
    chk(r, {rcs_pkg::BC_SW_EN_RST, rcs_pkg::BC_FAST_RST, 5'h00, det});
    wr(4'h9, 8'hFF);
    rd(4'h9);
    chk(r, 8'h00);
    done("reset");
    pwrt_n <= 1'b0;
    ev(0);
    wait_load();
    chk(n >= PW - 2 && n <= PW + 3, 16'h1);
    chk(v, rcs_pkg::RESET_VECTOR);
    chk(core_rst, 1'b0);
    rd(rcs_pkg::ADDR_PWR_CTRL);
    chk(r & 8'hFE, 8'h0C);
    pin_low(8'(PW + 12));
    ev(0);
    wait_load();
    chk(n >= PW + 8 && n <= PW + 16, 16'h1);
    pwrt_n <= 1'b1;
    ev(0);
    wait_load();
    chk(n <= 4, 16'h1);
    osc_ok <= 1'b0;
    ev(0);
    repeat (10) @(posedge i_sys_clk);
    #1 chk(core_rst, 1'b1);
    osc_ok <= 1'b1;
    wait_load();
    chk(n <= 2, 16'h1);
    done("start-up");
    for (int k = 1; k < 7; k++)
    begin
      if (k == 3)
        continue;
      ini = {2'($urandom), 6'h0F};
      wr(rcs_pkg::ADDR_PWR_CTRL, ini);
      ev(k);
      wait_load();
      chk(v, rcs_pkg::RESET_VECTOR);
      rd(rcs_pkg::ADDR_PWR_CTRL);
      chk(r, f_flags(k, ini));
      rd(rcs_pkg::ADDR_STATUS);
      chk(r, 8'h18);
    end
    stk_en <= 1'b0;
    wr(rcs_pkg::ADDR_PWR_CTRL, 8'h0F);
    ev(5);
    repeat (4) @(posedge i_sys_clk);
    #1 chk(core_rst, 1'b0);
    rd(rcs_pkg::ADDR_PWR_CTRL);
    chk(r, 8'h0F);
    stk_en <= 1'b1;
    ev(3);
    wait_load();
    chk(v, rcs_pkg::RESET_VECTOR);
    rd(rcs_pkg::ADDR_STATUS);
    chk(r, 8'h08);
    done("causes");
    pin_low(8'h03);
    repeat (8)
    begin
      @(posedge i_sys_clk);
      #1 chk(core_rst, 1'b0);
    end
    pin_low(8'h28);
    repeat (30) @(posedge i_sys_clk);
    #1 chk(core_rst, 1'b1);
    wait_load();
    chk(v, rcs_pkg::RESET_VECTOR);
    rd(rcs_pkg::ADDR_PWR_CTRL);
    chk(r, 8'h07);
    rd(rcs_pkg::ADDR_STATUS);
    chk(r, 8'h08);
    for (int c = 3; c >= 0; c--)
    begin
      pin_en <= c[0];
      low_voltage_prog <= c[1];
      repeat (3) @(posedge i_sys_clk);
      #1 chk(gpio, c == 0);
      chk(pull, c == 0);
    end
    pin_low(8'h28);
    repeat (30) @(posedge i_sys_clk);
    #1 chk(core_rst, 1'b0);
    repeat (12) @(posedge i_sys_clk);
    pin_en <= 1'b1;
    done("pin");
    for (int m = 0; m < 4; m++)
    begin
      for (int s = 0; s < 4; s++)
      begin
        mode <= m[1:0];
        det <= 1'($urandom);
        sleep <= 1'($urandom);
        wr(rcs_pkg::ADDR_BOR_CTRL, {s[1:0], 6'h00});
        rd(rcs_pkg::ADDR_BOR_CTRL);
        chk(r, {s[1:0], 5'h00, det});
        chk(det_en, f_det(mode, s[1], sleep));
        chk(bg, f_bg(mode, s[0]));
      end
    end
    mode <= 2'h3;
    done("brown-out");
    sleep <= 1'b1;
    pc <= 15'($urandom);
    // Status is time-out 0, power-down 1 here, so both bits must move
    wr(rcs_pkg::ADDR_PWR_CTRL, 8'h0F);
    pin_low(8'h1E);
    wait_load();
    chk(v, rcs_pkg::RESET_VECTOR);
    rd(rcs_pkg::ADDR_STATUS);
    chk(r, 8'h10);
    rd(rcs_pkg::ADDR_PWR_CTRL);
    chk(r, 8'h07);
    ev(3);
    wait_load();
    chk(v, 15'(pc + 15'h0001));
    rd(rcs_pkg::ADDR_STATUS);
    chk(r, 8'h00);
    ev(7);
    wait_load();
    chk(v, 15'(pc + 15'h0001));
    @(posedge i_sys_clk);
    wait_load();
    chk(v, rcs_pkg::IRQ_VECTOR);
    chk(push, 1'b1);
    rd(rcs_pkg::ADDR_STATUS);
    chk(r, 8'h10);
    global_irq_enable <= 1'b0;
    ev(7);
    wait_load();
    chk(v, 15'(pc + 15'h0001));
    repeat (2) @(posedge i_sys_clk);
    #1 chk(pc_ld, 1'b0);
    global_irq_enable <= 1'b1;
    sleep <= 1'b0;
    done("sleep");
    give_verdict();
  end
endmodule
